// ==== core/dprpc_device_end.sv ====
// dual-port ram core with per-port control, mailbox and burst counter
// assumes both hosts run on clk and keep their pins synchronous to it
//
// How it works
// - low select input must be low
// - high select input must also be high
// - data driven only while output enable low
// - top two addresses are the mailboxes
// - opposite port write lowers mailbox interrupt
// - own mailbox read raises interrupt again
// - host sets slow select below 100 MHz
// - read/write low writes, high reads
// - ready asserted once port can operate
// - wrap interrupt low when unmasked bits all ones
// - wrap select low clears unmasked bits
// - wrap select high reloads from mirror
// - flow-through bypasses output register, else pipelined
`timescale 1ns/1ps
`include "dprpc_params.svh"

module dprpc_device_end #(
	parameter int ADDR_W       = `DPRPC_ADDR_W,
	parameter int DATA_W       = `DPRPC_DATA_W,
	parameter int READY_CYCLES = `DPRPC_READY_CYCLES
)(
	input  wire logic   clk,
	input  wire logic   rst_b,
	dprpc_port_if.dev   portL,
	dprpc_port_if.dev   portR,
	output logic        mailboxPendingL,
	output logic        mailboxPendingR
);

	// ------------------------------------------------------------
	// constants
	// ------------------------------------------------------------
	localparam int                DEPTH   = 1 << ADDR_W;
	localparam logic [ADDR_W-1:0] ONE     = ADDR_W'(1);
	localparam logic [ADDR_W-1:0] TOP     = '1;
	localparam logic [ADDR_W-1:0] OFS_L   = ADDR_W'(`DPRPC_MBOX_L_BELOW_TOP);
	localparam logic [ADDR_W-1:0] OFS_R   = ADDR_W'(`DPRPC_MBOX_R_BELOW_TOP);
	localparam logic [ADDR_W-1:0] ADR_RST = `DPRPC_ADDR_RST;
	localparam logic [ADDR_W-1:0] MSK_RST = `DPRPC_MASK_RST;
	localparam logic [15:0]       RDY_MAX = 16'(READY_CYCLES);

	// ------------------------------------------------------------
	// per-port pin arrays, index 0 left and 1 right
	// ------------------------------------------------------------
	logic              csLow_b   [2];
	logic              csHigh    [2];
	logic              oe_b      [2];
	logic              rw        [2];
	logic              flow_through_select     [2];
	logic              wrapSel   [2];
	logic              cntMskSel [2];
	logic              load_b    [2];
	logic              adv_b     [2];
	logic [ADDR_W-1:0] pinAddr   [2];
	logic [DATA_W-1:0] dq        [2];
	logic [ADDR_W-1:0] mboxAddr  [2];
	logic              wrEn      [2];
	logic              rdEn      [2];
	logic [ADDR_W-1:0] accAddr   [2];
	logic [DATA_W-1:0] outData   [2];
	logic              outOe     [2];
	logic              mbox_ff   [2];
	logic              wrapIrq_ff[2];

	assign csLow_b[0]   = portL.chipSelectLow_b;
	assign csLow_b[1]   = portR.chipSelectLow_b;
	assign csHigh[0]    = portL.chipSelectHigh;
	assign csHigh[1]    = portR.chipSelectHigh;
	assign oe_b[0]      = portL.outputEnable_b;
	assign oe_b[1]      = portR.outputEnable_b;
	assign rw[0]        = portL.readWrite;
	assign rw[1]        = portR.readWrite;
	assign flow_through_select[0]     = portL.flowThroughSelect;
	assign flow_through_select[1]     = portR.flowThroughSelect;
	assign wrapSel[0]   = portL.wrapSelect;
	assign wrapSel[1]   = portR.wrapSelect;
	assign cntMskSel[0] = portL.counterOrMaskSelect;
	assign cntMskSel[1] = portR.counterOrMaskSelect;
	assign load_b[0]    = portL.counterLoadStrobe_b;
	assign load_b[1]    = portR.counterLoadStrobe_b;
	assign adv_b[0]     = portL.counterAdvanceEn_b;
	assign adv_b[1]     = portR.counterAdvanceEn_b;
	assign pinAddr[0]   = portL.address;
	assign pinAddr[1]   = portR.address;
	assign dq[0]        = portL.dq;
	assign dq[1]        = portR.dq;

	// ------------------------------------------------------------
	// mailbox locations
	// ------------------------------------------------------------
	assign mboxAddr[0] = TOP - OFS_L;
	assign mboxAddr[1] = TOP - OFS_R;

	// ------------------------------------------------------------
	// ready after reset settles
	// ------------------------------------------------------------
	logic [15:0] rdyCnt_ff;
	logic        ready_ff;
	logic        rdyDone;

	assign rdyDone = (rdyCnt_ff >= RDY_MAX);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rdyCnt_ff <= 16'h0000;
			ready_ff  <= 1'b0;
		end
		else
		begin
			if (!rdyDone)
				rdyCnt_ff <= rdyCnt_ff + 16'h0001;
			ready_ff <= rdyDone;
		end
	end

	// ------------------------------------------------------------
	// memory array, both ports write here
	// ------------------------------------------------------------
	logic [DATA_W-1:0] mem [0:DEPTH-1];

	// same-address writes in one cycle are undefined; right lands last
	always_ff @(posedge clk)
	begin
		if (wrEn[0])
			mem[accAddr[0]] <= dq[0];
		if (wrEn[1])
			mem[accAddr[1]] <= dq[1];
	end

	// ------------------------------------------------------------
	// per-port control
	// ------------------------------------------------------------
	for (genvar p = 0; p < 2; p++)
	begin : g_port
		localparam int O = 1 - p;

		logic              selected;
		logic              loadNow;
		logic              advNow;
		logic              atMax;
		logic              hitMax;
		logic              setMb;
		logic              clrMb;
		logic [ADDR_W-1:0] cntInc;
		logic [ADDR_W-1:0] cntWrap;
		logic [ADDR_W-1:0] nxt_cnt;
		logic [ADDR_W-1:0] cnt_ff;
		logic [ADDR_W-1:0] mask_ff;
		logic [ADDR_W-1:0] mirror_ff;
		logic [DATA_W-1:0] rd1Data_ff;
		logic [DATA_W-1:0] pipeData_ff;
		logic              rd1Valid_ff;
		logic              pipeValid_ff;

		assign selected = ~csLow_b[p] & csHigh[p];
		assign wrEn[p]  = ready_ff & selected & ~rw[p];
		assign rdEn[p]  = ready_ff & selected & rw[p];
		assign loadNow  = ~load_b[p];
		assign advNow   = ~adv_b[p] & ~loadNow;
		assign accAddr[p] = loadNow ? pinAddr[p] : cnt_ff;

		// masked burst counter
		assign atMax   = (cnt_ff & mask_ff) == mask_ff;
		assign cntInc  = (((cnt_ff & mask_ff) + ONE) & mask_ff)
			| (cnt_ff & ~mask_ff);
		assign hitMax  = advNow & ~atMax
			& ((cntInc & mask_ff) == mask_ff);
		assign cntWrap = wrapSel[p] ? mirror_ff
			: (cnt_ff & ~mask_ff);
		assign nxt_cnt = (loadNow & cntMskSel[p]) ? pinAddr[p]
			: advNow ? (atMax ? cntWrap : cntInc)
			: cnt_ff;

		// mailbox flag, a new write wins over a read in the same cycle
		assign setMb = wrEn[O] & (accAddr[O] == mboxAddr[p]);
		assign clrMb = rdEn[p] & (accAddr[p] == mboxAddr[p]);

		always_ff @(posedge clk or negedge rst_b)
		begin
			if (!rst_b)
			begin
				cnt_ff        <= ADR_RST;
				mask_ff       <= MSK_RST;
				mirror_ff     <= ADR_RST;
				wrapIrq_ff[p] <= 1'b0;
				mbox_ff[p]    <= 1'b0;
			end
			else
			begin
				cnt_ff <= nxt_cnt;
				if (loadNow & cntMskSel[p])
					mirror_ff <= pinAddr[p];
				if (loadNow & ~cntMskSel[p])
					mask_ff <= pinAddr[p];
				if (loadNow | advNow)
					wrapIrq_ff[p] <= hitMax;
				mbox_ff[p] <= setMb | (mbox_ff[p] & ~clrMb);
			end
		end

		// read data path, one register flow-through, two pipelined
		always_ff @(posedge clk or negedge rst_b)
		begin
			if (!rst_b)
			begin
				rd1Data_ff   <= '0;
				pipeData_ff  <= '0;
				rd1Valid_ff  <= 1'b0;
				pipeValid_ff <= 1'b0;
			end
			else
			begin
				if (rdEn[p])
					rd1Data_ff <= mem[accAddr[p]];
				rd1Valid_ff  <= rdEn[p];
				pipeData_ff  <= rd1Data_ff;
				pipeValid_ff <= rd1Valid_ff;
			end
		end

		assign outData[p] = flow_through_select[p] ? rd1Data_ff : pipeData_ff;
		assign outOe[p]   = (flow_through_select[p] ? rd1Valid_ff : pipeValid_ff)
			& ~oe_b[p];
	end

	// ------------------------------------------------------------
	// drive pins back out
	// ------------------------------------------------------------
	assign portL.devData          = outData[0];
	assign portR.devData          = outData[1];
	assign portL.devDataOe        = outOe[0];
	assign portR.devDataOe        = outOe[1];
	assign portL.portReady        = ready_ff;
	assign portR.portReady        = ready_ff;
	assign portL.mailboxIrq_b     = ~mbox_ff[0];
	assign portR.mailboxIrq_b     = ~mbox_ff[1];
	assign portL.counterWrapIrq_b = ~wrapIrq_ff[0];
	assign portR.counterWrapIrq_b = ~wrapIrq_ff[1];
	assign mailboxPendingL        = mbox_ff[0];
	assign mailboxPendingR        = mbox_ff[1];

endmodule : dprpc_device_end

// ==== core/dprpc_host_end.sv ====
// host sequencer driving one ram port from a simple request port
// assumes the device shares clk and answers on the same pin bundle
`timescale 1ns/1ps
`include "dprpc_params.svh"

module dprpc_host_end #(
	parameter int ADDR_W  = `DPRPC_ADDR_W,
	parameter int DATA_W  = `DPRPC_DATA_W,
	parameter int CLK_MHZ = `DPRPC_CLK_MHZ
)(
	input  wire logic              clk,
	input  wire logic              rst_b,
	dprpc_port_if.host             port,
	input  wire logic              reqValid,
	input  wire logic              reqWrite,
	input  wire logic              reqBurst,
	input  wire logic              reqMask,
	input  wire logic [ADDR_W-1:0] reqAddr,
	input  wire logic [DATA_W-1:0] reqData,
	input  wire logic              flowThrough,
	input  wire logic              wrapSelect,
	output logic                   reqReady,
	output logic                   rspValid,
	output logic [DATA_W-1:0]      rspData,
	output logic                   portReady,
	output logic                   mailboxIrq,
	output logic                   counterWrapIrq
);

	// ------------------------------------------------------------
	// pin registers
	// ------------------------------------------------------------
	dprpc_pkg::dprpc_host_state_t state_ff;
	logic              cs_ff;
	logic              rw_ff;
	logic              load_ff;
	logic              adv_ff;
	logic              cntMsk_ff;
	logic              oe_ff;
	logic              dataOe_ff;
	logic              ft_ff;
	logic              wrap_ff;
	logic              wait_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [DATA_W-1:0] data_ff;
	logic              take;
	logic              lastWait;

	assign reqReady = (state_ff == dprpc_pkg::HOST_IDLE) & portReady;
	assign take     = reqValid & reqReady;
	assign lastWait = (wait_ff == ~ft_ff);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_ff  <= dprpc_pkg::HOST_IDLE;
			cs_ff     <= 1'b0;
			rw_ff     <= 1'b1;
			load_ff   <= 1'b0;
			adv_ff    <= 1'b0;
			cntMsk_ff <= 1'b1;
			oe_ff     <= 1'b0;
			dataOe_ff <= 1'b0;
			wait_ff   <= 1'b0;
			addr_ff   <= '0;
			data_ff   <= '0;
			rspValid  <= 1'b0;
			rspData   <= '0;
		end
		else
		begin
			rspValid <= 1'b0;
			case (state_ff)
				dprpc_pkg::HOST_IDLE:
				begin
					if (take)
					begin
						cs_ff     <= 1'b1;
						rw_ff     <= ~reqWrite;
						load_ff   <= ~reqBurst;
						adv_ff    <= reqBurst;
						cntMsk_ff <= ~reqMask;
						addr_ff   <= reqAddr;
						data_ff   <= reqData;
						dataOe_ff <= reqWrite;
						state_ff  <= dprpc_pkg::HOST_ACCESS;
					end
				end
				dprpc_pkg::HOST_ACCESS:
				begin
					cs_ff     <= 1'b0;
					load_ff   <= 1'b0;
					adv_ff    <= 1'b0;
					dataOe_ff <= 1'b0;
					wait_ff   <= 1'b0;
					oe_ff     <= rw_ff;
					state_ff  <= rw_ff ? dprpc_pkg::HOST_READ
						: dprpc_pkg::HOST_IDLE;
				end
				dprpc_pkg::HOST_READ:
				begin
					if (lastWait)
					begin
						rspData  <= port.dq;
						rspValid <= 1'b1;
						oe_ff    <= 1'b0;
						state_ff <= dprpc_pkg::HOST_IDLE;
					end
					else
						wait_ff <= 1'b1;
				end
				default:
					state_ff <= dprpc_pkg::HOST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// mode pins and status capture
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ft_ff          <= 1'b0;
			wrap_ff        <= 1'b0;
			portReady      <= 1'b0;
			mailboxIrq     <= 1'b0;
			counterWrapIrq <= 1'b0;
		end
		else
		begin
			if (state_ff == dprpc_pkg::HOST_IDLE)
			begin
				ft_ff   <= flowThrough;
				wrap_ff <= wrapSelect;
			end
			portReady      <= port.portReady;
			mailboxIrq     <= ~port.mailboxIrq_b;
			counterWrapIrq <= ~port.counterWrapIrq_b;
		end
	end

	// ------------------------------------------------------------
	// pins
	// ------------------------------------------------------------
	assign port.chipSelectLow_b     = ~cs_ff;
	assign port.chipSelectHigh      = cs_ff;
	assign port.outputEnable_b      = ~oe_ff;
	assign port.readWrite           = rw_ff;
	assign port.slowClockSelect     = (CLK_MHZ < `DPRPC_SLOW_LIMIT_MHZ);
	assign port.flowThroughSelect   = ft_ff;
	assign port.wrapSelect          = wrap_ff;
	assign port.counterOrMaskSelect = cntMsk_ff;
	assign port.counterLoadStrobe_b = ~load_ff;
	assign port.counterAdvanceEn_b  = ~adv_ff;
	assign port.address             = addr_ff;
	assign port.hostData            = data_ff;
	assign port.hostDataOe          = dataOe_ff;

endmodule : dprpc_host_end

// ==== inc/dprpc_params.svh ====
// constants shared by both ends of the dual-port ram port link
// assumes a single 100 MHz clock for both ends
`ifndef DPRPC_PARAMS_SVH
`define DPRPC_PARAMS_SVH

// ------------------------------------------------------------
// array geometry
// ------------------------------------------------------------
`define DPRPC_ADDR_W          17
`define DPRPC_DATA_W          72

// ------------------------------------------------------------
// mailbox placement, counted down from the top address
// ------------------------------------------------------------
`define DPRPC_MBOX_L_BELOW_TOP 0
`define DPRPC_MBOX_R_BELOW_TOP 1

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define DPRPC_CLK_MHZ         100
`define DPRPC_SLOW_LIMIT_MHZ  100
`define DPRPC_READY_CYCLES    16

// ------------------------------------------------------------
// reset and idle levels
// ------------------------------------------------------------
`define DPRPC_IRQ_IDLE        1'b1
`define DPRPC_ADDR_RST        17'h0_0000
`define DPRPC_MASK_RST        17'h1_FFFF

`endif

// ==== inc/dprpc_pkg.sv ====
// types used by the host end of the dual-port ram port link
// assumes nothing of its surroundings
package dprpc_pkg;

	// ------------------------------------------------------------
	// host sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		HOST_IDLE,
		HOST_ACCESS,
		HOST_READ
	} dprpc_host_state_t;

endpackage : dprpc_pkg

// ==== inc/dprpc_port_if.sv ====
// pin bundle of one ram port between host and device
// assumes the bench instantiates one bundle per port
`timescale 1ns/1ps
`include "dprpc_params.svh"

interface dprpc_port_if #(
	parameter int ADDR_W = `DPRPC_ADDR_W,
	parameter int DATA_W = `DPRPC_DATA_W
);
	logic              chipSelectLow_b;
	logic              chipSelectHigh;
	logic              outputEnable_b;
	logic              readWrite;
	logic              slowClockSelect;
	logic              flowThroughSelect;
	logic              wrapSelect;
	logic              counterOrMaskSelect;
	logic              counterLoadStrobe_b;
	logic              counterAdvanceEn_b;
	logic [ADDR_W-1:0] address;
	logic [DATA_W-1:0] hostData;
	logic              hostDataOe;
	logic [DATA_W-1:0] devData;
	logic              devDataOe;
	logic              portReady;
	logic              mailboxIrq_b;
	logic              counterWrapIrq_b;
	wire  [DATA_W-1:0] dq;

	// ------------------------------------------------------------
	// shared data wire level from the two drive enables
	// ------------------------------------------------------------
	assign dq = devDataOe ? devData : hostDataOe ? hostData : ~hostData;

	modport dev (
		input  chipSelectLow_b,
		input  chipSelectHigh,
		input  outputEnable_b,
		input  readWrite,
		input  slowClockSelect,
		input  flowThroughSelect,
		input  wrapSelect,
		input  counterOrMaskSelect,
		input  counterLoadStrobe_b,
		input  counterAdvanceEn_b,
		input  address,
		input  dq,
		output devData,
		output devDataOe,
		output portReady,
		output mailboxIrq_b,
		output counterWrapIrq_b
	);

	modport host (
		output chipSelectLow_b,
		output chipSelectHigh,
		output outputEnable_b,
		output readWrite,
		output slowClockSelect,
		output flowThroughSelect,
		output wrapSelect,
		output counterOrMaskSelect,
		output counterLoadStrobe_b,
		output counterAdvanceEn_b,
		output address,
		output hostData,
		output hostDataOe,
		input  dq,
		input  portReady,
		input  mailboxIrq_b,
		input  counterWrapIrq_b
	);

endinterface : dprpc_port_if

// ==== verification/dprpc_link_assertions.sv ====
// checker of the left ram port and the mailbox path between ports
// assumes the bench wires both pin bundles in, one clock for both
`timescale 1ns/1ps

module dprpc_link_assertions #(
	parameter int ADDR_W = 17
)(
	input wire logic              clk,
	input wire logic              rst_b,
	input wire logic              chipSelectLow_b,
	input wire logic              chipSelectHigh,
	input wire logic              outputEnable_b,
	input wire logic              readWrite,
	input wire logic              counterLoadStrobe_b,
	input wire logic              counterAdvanceEn_b,
	input wire logic [ADDR_W-1:0] address,
	input wire logic              devDataOe,
	input wire logic              portReady,
	input wire logic              mailboxIrq_b,
	input wire logic              counterWrapIrq_b,
	input wire logic              rChipSelectLow_b,
	input wire logic              rChipSelectHigh,
	input wire logic              rReadWrite,
	input wire logic              rCounterLoadStrobe_b,
	input wire logic [ADDR_W-1:0] rAddress,
	input wire logic              rPortReady,
	input wire logic              rMailboxIrq_b
);
	// ------------------------------------------------------------
	// decoded accesses
	// ------------------------------------------------------------
	wire logic [ADDR_W-1:0] boxL;
	wire logic [ADDR_W-1:0] boxR;
	wire logic              selL;
	wire logic              selR;
	wire logic              selRdL;
	wire logic              readBoxL;
	wire logic              writeBoxL;
	wire logic              writeBoxR;
	wire logic              advL;
	assign boxL = '1;
	assign boxR = {{(ADDR_W-1){1'b1}}, 1'b0};
	assign selL = portReady & ~chipSelectLow_b & chipSelectHigh;
	assign selR = rPortReady & ~rChipSelectLow_b & rChipSelectHigh;
	assign selRdL = selL & readWrite;
	assign readBoxL = selRdL & ~counterLoadStrobe_b & (address == boxL);
	assign writeBoxL = selR & ~rReadWrite & ~rCounterLoadStrobe_b
		& (rAddress == boxL);
	assign writeBoxR = selL & ~readWrite & ~counterLoadStrobe_b
		& (address == boxR);
	assign advL = selL & ~counterAdvanceEn_b & counterLoadStrobe_b;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_oe_gates_drive: assert property (devDataOe |-> !outputEnable_b)
		else $error("data driven with output enable high");
	a_unselected_quiet: assert property (!selRdL [*2] |=> !devDataOe)
		else $error("data driven without a selected read");
	a_ready_holds: assert property (portReady |=> portReady)
		else $error("ready dropped");
	a_box_write_sets: assert property (writeBoxL |=> !mailboxIrq_b)
		else $error("left mailbox interrupt not raised");
	a_irq_has_cause: assert property ($fell(mailboxIrq_b) |-> $past(writeBoxL))
		else $error("left mailbox interrupt without a write");
	a_irq_stays_low: assert property (!mailboxIrq_b && !readBoxL |=> !mailboxIrq_b)
		else $error("left mailbox interrupt lost");
	a_own_read_clears: assert property (readBoxL && !writeBoxL |=> mailboxIrq_b)
		else $error("left mailbox interrupt not released");
	a_right_box_sets: assert property (writeBoxR |=> !rMailboxIrq_b)
		else $error("right mailbox write not seen");
	a_wrap_has_cause: assert property ($fell(counterWrapIrq_b) |-> $past(advL))
		else $error("wrap interrupt without an advance");

endmodule : dprpc_link_assertions

// ==== verification/test_dual_port_ram_port_control.sv ====
// self-checking bench of two hosts facing the dual-port ram core
// assumes the design files and the pin bundle are compiled first
`timescale 1ns/1ps

module test_dual_port_ram_port_control;
	localparam int AW = 17;
	localparam int DW = 72;
	logic          clk = 1'b0;
	logic          rst_b = 1'b0;
	logic          reqValid [2];
	logic          reqWrite [2];
	logic          reqBurst [2];
	logic          reqMask [2];
	logic [AW-1:0] reqAddr [2];
	logic [DW-1:0] reqData [2];
	logic          flowThrough [2];
	logic          wrapSelect [2];
	logic          reqReady [2];
	logic          rspValid [2];
	logic [DW-1:0] rspData [2];
	logic          portReady [2];
	logic          mailboxIrq [2];
	logic          counterWrapIrq [2];
	logic          mailboxPendingL;
	logic          mailboxPendingR;
	int            numErrors = 0;
	int            comparisons = 0;
	int            cycles = 0;

	always #5 clk = ~clk;

	// ------------------------------------------------------------
	// two hosts, the core and the checker
	// ------------------------------------------------------------
	dprpc_port_if portIf [2] ();
	dprpc_device_end #(.READY_CYCLES(2)) dprpc_device_end_inst (
		.clk(clk), .rst_b(rst_b), .portL(portIf[0]), .portR(portIf[1]),
		.mailboxPendingL(mailboxPendingL), .mailboxPendingR(mailboxPendingR));
	for (genvar g = 0; g < 2; g++)
	begin : gHost
		dprpc_host_end dprpc_host_end_inst (
			.clk(clk), .rst_b(rst_b), .port(portIf[g]),
			.reqValid(reqValid[g]), .reqWrite(reqWrite[g]),
			.reqBurst(reqBurst[g]), .reqMask(reqMask[g]),
			.reqAddr(reqAddr[g]), .reqData(reqData[g]),
			.flowThrough(flowThrough[g]), .wrapSelect(wrapSelect[g]),
			.reqReady(reqReady[g]), .rspValid(rspValid[g]),
			.rspData(rspData[g]), .portReady(portReady[g]),
			.mailboxIrq(mailboxIrq[g]), .counterWrapIrq(counterWrapIrq[g]));
	end
	dprpc_link_assertions dprpc_link_assertions_inst (
		.clk(clk), .rst_b(rst_b),
		.chipSelectLow_b(portIf[0].chipSelectLow_b),
		.chipSelectHigh(portIf[0].chipSelectHigh),
		.outputEnable_b(portIf[0].outputEnable_b),
		.readWrite(portIf[0].readWrite),
		.counterLoadStrobe_b(portIf[0].counterLoadStrobe_b),
		.counterAdvanceEn_b(portIf[0].counterAdvanceEn_b),
		.address(portIf[0].address), .devDataOe(portIf[0].devDataOe),
		.portReady(portIf[0].portReady),
		.mailboxIrq_b(portIf[0].mailboxIrq_b),
		.counterWrapIrq_b(portIf[0].counterWrapIrq_b),
		.rChipSelectLow_b(portIf[1].chipSelectLow_b),
		.rChipSelectHigh(portIf[1].chipSelectHigh),
		.rReadWrite(portIf[1].readWrite),
		.rCounterLoadStrobe_b(portIf[1].counterLoadStrobe_b),
		.rAddress(portIf[1].address), .rPortReady(portIf[1].portReady),
		.rMailboxIrq_b(portIf[1].mailboxIrq_b));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [DW-1:0] pat(input int k);
		return {9{8'(k) ^ 8'hA5}};
	endfunction : pat

	task automatic wrap_up();
		if (numErrors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			numErrors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic idle(input int k);
		repeat (k) @(negedge clk);
	endtask : idle

	task automatic setMode(input logic f, input logic w);
		@(posedge clk);
		flowThrough[0] <= f;
		flowThrough[1] <= f;
		wrapSelect[0] <= w;
		wrapSelect[1] <= w;
	endtask : setMode

	task automatic req(input int p, input logic wr, input logic burst,
		input logic [AW-1:0] a, input logic [DW-1:0] d);
		int n;
		n = 0;
		@(posedge clk);
		reqValid[p] <= 1'b1;
		reqWrite[p] <= wr;
		reqBurst[p] <= burst;
		reqAddr[p] <= a;
		reqData[p] <= d;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (reqReady[p] !== 1'b1 && n < 100);
		check(reqReady[p], 1'b1);
		@(posedge clk);
		reqValid[p] <= 1'b0;
	endtask : req

	task automatic rd(input int p, input logic burst, input logic [AW-1:0] a,
		input logic [DW-1:0] exp);
		int n;
		n = 0;
		req(p, 1'b0, burst, a, '0);
		while (rspValid[p] !== 1'b1 && n < 20)
		begin
			@(negedge clk);
			n++;
		end
		check(rspValid[p], 1'b1);
		check(rspData[p], exp);
	endtask : rd

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			numErrors++;
			wrap_up();
		end
	end

	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial
	begin
		for (int p = 0; p < 2; p++)
		begin
			reqValid[p] = 1'b0;
			reqWrite[p] = 1'b0;
			reqBurst[p] = 1'b0;
			reqMask[p] = 1'b0;
			reqAddr[p] = '0;
			reqData[p] = '0;
			flowThrough[p] = 1'b0;
			wrapSelect[p] = 1'b0;
		end
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		idle(8);
		check(portReady[0], 1'b1);
		check(portReady[1], 1'b1);
		check(portIf[0].slowClockSelect, 1'b0);
		check(mailboxIrq[0], 1'b0);
		// cross-port transfers in pipelined then flow-through mode
		for (int f = 0; f < 2; f++)
		begin
			setMode(f[0], 1'b0);
			req(0, 1'b1, 1'b0, 17'h0_0010 + 17'(f), pat(f));
			rd(1, 1'b0, 17'h0_0010 + 17'(f), pat(f));
			req(1, 1'b1, 1'b0, 17'h0_0020 + 17'(f), pat(f + 4));
			rd(0, 1'b0, 17'h0_0020 + 17'(f), pat(f + 4));
		end
		// mailbox message passing both ways
		req(1, 1'b1, 1'b0, 17'h1_FFFF, pat(8));
		idle(4);
		check(mailboxIrq[0], 1'b1);
		check(mailboxPendingL, 1'b1);
		req(1, 1'b1, 1'b0, 17'h1_FFFF, pat(9));
		rd(0, 1'b0, 17'h0_0010, pat(0));
		check(mailboxIrq[0], 1'b1);
		rd(0, 1'b0, 17'h1_FFFF, pat(9));
		idle(4);
		check(mailboxIrq[0], 1'b0);
		req(0, 1'b1, 1'b0, 17'h1_FFFE, pat(10));
		idle(4);
		check(mailboxIrq[1], 1'b1);
		check(mailboxPendingR, 1'b1);
		rd(1, 1'b0, 17'h1_FFFE, pat(10));
		idle(4);
		check(mailboxIrq[1], 1'b0);
		// burst counter wrap, clearing then reloading
		req(1, 1'b1, 1'b0, 17'h0_0000, pat(11));
		req(1, 1'b1, 1'b0, 17'h1_FFFD, pat(12));
		for (int w = 0; w < 2; w++)
		begin
			setMode(1'b1, w[0]);
			rd(0, 1'b0, 17'h1_FFFD, pat(12));
			rd(0, 1'b1, '0, pat(12));
			rd(0, 1'b1, '0, pat(10));
			check(counterWrapIrq[0], 1'b1);
			rd(0, 1'b1, '0, pat(9));
			check(counterWrapIrq[0], 1'b0);
			rd(0, 1'b1, '0, w ? pat(12) : pat(11));
		end
		// partial mask: only bit 0 counts, higher bits kept on wrap
		setMode(1'b1, 1'b0);
		reqMask[0] <= 1'b1;
		req(0, 1'b1, 1'b0, 17'h0_0001, pat(13));
		reqMask[0] <= 1'b0;
		rd(0, 1'b0, 17'h0_0010, pat(0));
		rd(0, 1'b1, '0, pat(0));
		check(counterWrapIrq[0], 1'b1);
		rd(0, 1'b1, '0, pat(1));
		rd(0, 1'b1, '0, pat(0));
		wrap_up();
	end

endmodule : test_dual_port_ram_port_control
